/* hdl/dio_pkg.sv */
// constants, register map and carrier types for the drive input conditioner
// assumes one 40 MHz clock and an ahb-lite master on the register port
package dio_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned QUAL_MS = 20;
    localparam int unsigned QUAL_CYC = (CLK_HZ / 1000) * QUAL_MS;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned CLK_NS = 25;

    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h04;
    localparam logic [7:0] A_IRQ_ST = 8'h08;
    localparam logic [7:0] A_IRQ_MASK = 8'h0c;
    localparam logic [7:0] A_ANLG1 = 8'h10;
    localparam logic [7:0] A_ANLG2 = 8'h14;
    localparam logic [7:0] A_ANLG_CAL = 8'h18;
    localparam logic [7:0] A_CML_REF = 8'h1c;
    localparam logic [7:0] A_CML_ERR = 8'h20;
    localparam logic [7:0] A_CML_LIM = 8'h24;
    localparam logic [7:0] A_FIRE_US = 8'h28;
    localparam logic [7:0] A_GAIN2 = 8'h2c;

    // status field positions
    localparam int unsigned S_BASE = 0;
    localparam int unsigned S_EXP = 1;
    localparam int unsigned S_BRUSH_OK = 5;
    localparam int unsigned S_INCH2 = 6;
    localparam int unsigned S_OCL_EN = 7;
    localparam int unsigned S_PRESET = 8;
    localparam int unsigned S_POT_DEC = 10;
    localparam int unsigned S_POT_INC = 11;
    localparam int unsigned S_BRIDGE = 12;
    localparam int unsigned S_EXP_OK = 13;
    localparam int unsigned S_ARM_OK = 14;
    // control field positions
    localparam int unsigned C_SEL = 0;
    localparam logic [1:0] CTRL_SEL_RST = 2'h1;
    localparam logic [1:0] SEL_BRUSH = 2'h1;
    localparam logic [1:0] SEL_INCH = 2'h2;
    localparam logic [1:0] SEL_OCL = 2'h3;
    // interrupt bits: expansion inputs qualified on, brushes worn
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned I_BRUSH = 4;

    localparam logic [15:0] GAIN_ONE = 16'h0100;
    localparam logic [15:0] LIM_RST = 16'h7fff;
    localparam logic [15:0] RATE_RST = 16'h0010;

    typedef enum logic [1:0] {EXP_ABSENT, EXP_PRESENT, EXP_FAILED} exp_state_e;

    typedef struct packed {
        logic signed [15:0] ref_sel;
        logic signed [15:0] feedback;
    } cml_in_s;

    typedef struct packed {
        logic brush_ok;
        logic inch2;
        logic ocl_en;
    } base_fn_s;
endpackage

/* hdl/dio_persist.sv */
// persistence filter for one asserted-high input already in the clk domain
// assumes the input has passed a two flop synchroniser
`timescale 1ns/1ps
module dio_persist #(
    parameter int unsigned CYCLES = 800000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic level,
    output logic qual
);
    localparam int unsigned CW = $clog2(CYCLES + 2);
    logic [CW-1:0] cnt_q;
    logic qual_q;
    wire done = (cnt_q > CW'(CYCLES));

    always_ff @(posedge clk) begin
        if (srst || !level) begin
            cnt_q <= '0;
            qual_q <= 1'b0;
        end else begin
            if (!done) begin
                cnt_q <= cnt_q + CW'(1);
            end
            qual_q <= done;
        end
    end
    assign qual = qual_q;

    a_persist_short : assert property (@(posedge clk) disable iff (srst)
        $rose(qual) |-> $past(cnt_q) > CW'(CYCLES))
        else $error("input qualified too early");
    a_persist_drop : assert property (@(posedge clk) disable iff (srst)
        !level |=> !qual)
        else $error("qualified input not dropped");
endmodule

/* hdl/dio_conditioner.sv */
// drive digital input conditioner with ahb-lite register slave
// assumes pins are asynchronous and the expansion kit reports presence and diagnostics
`timescale 1ns/1ps
module dio_conditioner #(
    parameter int unsigned QUAL_CYCLES = dio_pkg::QUAL_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic base_discrete_input,
    input wire logic [3:0] expansion_pins,
    input wire logic exp_installed,
    input wire logic exp_diag_fail,
    input wire logic reverse_bridge_active,
    input wire logic [15:0] analog_raw_first,
    input wire logic [15:0] analog_raw_second,
    input wire dio_pkg::cml_in_s cml_in,
    input wire logic [15:0] fire_cycles,
    output logic [1:0] preset_sel,
    output logic pot_decrement,
    output logic pot_increment,
    output logic armature_permit,
    output dio_pkg::base_fn_s base_fn,
    output logic irq
);
    // pin synchronisers
    logic [5:0] meta_q, sync_q;
    logic [3:0] exp_qual;
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {exp_installed, base_discrete_input, expansion_pins};
            sync_q <= meta_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_q
            dio_persist #(.CYCLES(QUAL_CYCLES)) u_persist (
                .clk(clk),
                .srst(srst),
                .level(sync_q[gi]),
                .qual(exp_qual[gi])
            );
        end
    endgenerate

    wire base_on = sync_q[4];
    wire exp_present = sync_q[5];
    logic fail_meta_q;
    logic fail_q;
    dio_pkg::exp_state_e exp_st;
    // diagnostics flag comes from the expansion board, so two flops as well
    always_ff @(posedge clk) begin
        if (srst) begin
            fail_meta_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            fail_meta_q <= exp_diag_fail;
            fail_q <= fail_meta_q;
        end
    end
    assign exp_st = fail_q ? dio_pkg::EXP_FAILED : (exp_present ? dio_pkg::EXP_PRESENT : dio_pkg::EXP_ABSENT);
    wire exp_ok = (exp_st == dio_pkg::EXP_PRESENT);
    wire [3:0] exp_vis = exp_ok ? exp_qual : 4'h0;

    // registers
    localparam int unsigned IRQ_W_L = dio_pkg::IRQ_W;
    logic [1:0] sel_q;
    logic [IRQ_W_L-1:0] ist_q, imask_q;
    logic [15:0] gain1_q, gain2_q, lim_q, rate_q;
    logic signed [7:0] zero1_q, zero2_q;
    logic signed [15:0] cref_q;
    logic signed [15:0] cerr_q;
    logic signed [15:0] an1_q, an2_q;
    logic [15:0] fire_us_q;
    logic [1:0] preset_q;
    logic dec_q, inc_q, arm_q, bridge_q;
    dio_pkg::base_fn_s fn_q;

    // base function decode
    dio_pkg::base_fn_s fn_d;
    assign fn_d.brush_ok = (sel_q == dio_pkg::SEL_BRUSH) && base_on;
    assign fn_d.inch2 = (sel_q == dio_pkg::SEL_INCH) && base_on;
    assign fn_d.ocl_en = (sel_q == dio_pkg::SEL_OCL) && base_on;
    wire brush_worn = (sel_q == dio_pkg::SEL_BRUSH) && !base_on;

    function automatic logic signed [15:0] scale(input logic [15:0] raw, input logic signed [7:0] zero,
                                                  input logic [15:0] gain);
        logic signed [33:0] diff;
        logic signed [33:0] p;
        // widen before the product so no bits of it are lost
        diff = 34'($signed({1'b0, raw})) - 34'(zero);
        p = diff * 34'($signed({1'b0, gain}));
        scale = 16'(p >>> 8);
    endfunction

    // amplitude then rate limit on the selected reference
    wire signed [15:0] lim_pos = $signed(lim_q);
    wire signed [15:0] amp = (cml_in.ref_sel > lim_pos) ? lim_pos :
                             (cml_in.ref_sel < -lim_pos) ? -lim_pos : cml_in.ref_sel;
    wire signed [16:0] step = 17'(amp) - 17'(cref_q);
    wire signed [16:0] rate_s = $signed({1'b0, rate_q});
    wire signed [15:0] cref_d = (step > rate_s) ? 16'(17'(cref_q) + rate_s) :
                                (step < -rate_s) ? 16'(17'(cref_q) - rate_s) : amp;
    wire [31:0] fire_prod = 32'(fire_cycles) * 32'(dio_pkg::CLK_NS);
    wire [4:0] ev = {brush_worn, exp_vis};

    always_ff @(posedge clk) begin
        if (srst) begin
            preset_q <= 2'h0;
            dec_q <= 1'b0;
            inc_q <= 1'b0;
            arm_q <= 1'b0;
            bridge_q <= 1'b0;
            fn_q <= '0;
            cref_q <= '0;
            cerr_q <= '0;
            an1_q <= '0;
            an2_q <= '0;
            fire_us_q <= '0;
        end else begin
            preset_q <= exp_vis[1:0];
            dec_q <= exp_vis[2];
            inc_q <= exp_vis[3];
            arm_q <= (exp_st != dio_pkg::EXP_FAILED);
            bridge_q <= reverse_bridge_active;
            fn_q <= fn_d;
            cref_q <= cref_d;
            cerr_q <= 16'(cref_d - cml_in.feedback);
            an1_q <= exp_ok ? scale(analog_raw_first, zero1_q, gain1_q) : 16'h0000;
            an2_q <= exp_ok ? scale(analog_raw_second, zero2_q, gain2_q) : 16'h0000;
            fire_us_q <= 16'(fire_prod / 32'(dio_pkg::NS_PER_US));
        end
    end
    assign preset_sel = preset_q;
    assign pot_decrement = dec_q;
    assign pot_increment = inc_q;
    assign armature_permit = arm_q;
    assign base_fn = fn_q;
    assign irq = |(ist_q & imask_q);

    // ahb-lite slave, zero wait state
    logic wr_q;
    logic [7:0] wa_q;
    logic [31:0] rd_mux;
    wire take = hsel && hready && htrans[1];
    wire wr = wr_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_q <= take && hwrite;
            wa_q <= haddr[7:0];
            if (take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire [31:0] status_w = {17'h0, arm_q, exp_ok, bridge_q, inc_q, dec_q, preset_q,
                            fn_q.ocl_en, fn_q.inch2, fn_q.brush_ok, exp_vis, base_on};
    always_comb begin
        unique case (haddr[7:0])
            dio_pkg::A_STATUS: rd_mux = status_w;
            dio_pkg::A_CTRL: rd_mux = {30'h0, sel_q};
            dio_pkg::A_IRQ_ST: rd_mux = {27'h0, ist_q};
            dio_pkg::A_IRQ_MASK: rd_mux = {27'h0, imask_q};
            dio_pkg::A_ANLG1: rd_mux = {{16{an1_q[15]}}, an1_q};
            dio_pkg::A_ANLG2: rd_mux = {{16{an2_q[15]}}, an2_q};
            dio_pkg::A_ANLG_CAL: rd_mux = {zero2_q, zero1_q, gain1_q};
            dio_pkg::A_CML_REF: rd_mux = {{16{cref_q[15]}}, cref_q};
            dio_pkg::A_CML_ERR: rd_mux = {{16{cerr_q[15]}}, cerr_q};
            dio_pkg::A_CML_LIM: rd_mux = {rate_q, lim_q};
            dio_pkg::A_FIRE_US: rd_mux = {16'h0, fire_us_q};
            dio_pkg::A_GAIN2: rd_mux = {16'h0, gain2_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // interrupt status: set wins over write-one-to-clear
    logic [4:0] ev_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_q <= dio_pkg::CTRL_SEL_RST;
            imask_q <= '0;
            ist_q <= '0;
            ev_q <= '0;
            gain1_q <= dio_pkg::GAIN_ONE;
            gain2_q <= dio_pkg::GAIN_ONE;
            zero1_q <= '0;
            zero2_q <= '0;
            lim_q <= dio_pkg::LIM_RST;
            rate_q <= dio_pkg::RATE_RST;
        end else begin
            ev_q <= ev;
            ist_q <= ((wr && wa_q == dio_pkg::A_IRQ_ST) ? (ist_q & ~hwdata[4:0]) : ist_q) | (ev & ~ev_q);
            if (wr && wa_q == dio_pkg::A_CTRL) begin
                sel_q <= hwdata[1:0];
            end
            if (wr && wa_q == dio_pkg::A_IRQ_MASK) begin
                imask_q <= hwdata[4:0];
            end
            if (wr && wa_q == dio_pkg::A_ANLG_CAL) begin
                gain1_q <= hwdata[15:0];
                zero1_q <= hwdata[23:16];
                zero2_q <= hwdata[31:24];
            end
            if (wr && wa_q == dio_pkg::A_GAIN2) begin
                gain2_q <= hwdata[15:0];
            end
            if (wr && wa_q == dio_pkg::A_CML_LIM) begin
                lim_q <= {1'b0, hwdata[14:0]};
                rate_q <= hwdata[31:16];
            end
        end
    end

    sequence s_exp_gone;
        !exp_ok ##1 1'b1;
    endsequence
    a_exp_hidden : assert property (@(posedge clk) disable iff (srst)
        s_exp_gone |-> (preset_q == 2'h0 && !dec_q && !inc_q && an1_q == 16'h0000))
        else $error("expansion reading shown without board");
    a_arm_block : assert property (@(posedge clk) disable iff (srst)
        fail_q |=> !armature_permit)
        else $error("armature permitted with failed board");
    a_err_diff : assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> cerr_q == 16'($past(cref_d) - $past(cml_in.feedback)))
        else $error("current loop error mismatch");
    a_ref_rate : assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> (17'(cref_q) - 17'($past(cref_q)) <= $past(rate_s)) &&
        (17'(cref_q) - 17'($past(cref_q)) >= -$past(rate_s)))
        else $error("reference stepped faster than rate");
    a_brush_map : assert property (@(posedge clk) disable iff (srst)
        (sel_q == dio_pkg::SEL_BRUSH) |=> fn_q.brush_ok == $past(base_on))
        else $error("brush state wrong");
    a_inch_map : assert property (@(posedge clk) disable iff (srst)
        (sel_q == dio_pkg::SEL_INCH) |=> fn_q.inch2 == $past(base_on) && !fn_q.brush_ok)
        else $error("inching select wrong");
    a_ocl_map : assert property (@(posedge clk) disable iff (srst)
        (sel_q == dio_pkg::SEL_OCL) |=> fn_q.ocl_en == $past(base_on) && !fn_q.inch2)
        else $error("outer loop enable wrong");
    a_pot_cmd : assert property (@(posedge clk) disable iff (srst)
        exp_ok ##1 exp_ok |-> {inc_q, dec_q} == $past(exp_qual[3:2]))
        else $error("pot command mismatch");
    a_bridge_dir : assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> bridge_q == $past(reverse_bridge_active))
        else $error("bridge flag wrong");
endmodule

/* verif/field_contacts.sv */
// field switch and contact model driving the conditioner pins
// assumes the bench changes its commands right after a rising clk edge
`timescale 1ns/1ps
module field_contacts (
    input wire logic base_closed,
    input wire logic [3:0] exp_closed,
    input wire logic board_fitted,
    output logic base_discrete_input,
    output logic [3:0] expansion_pins,
    output logic exp_installed
);
    // open contact rests at common, closed contact at supply
    assign base_discrete_input = base_closed;
    // missing board leaves terminals floating; show them asserted so only the gating hides them
    assign expansion_pins = board_fitted ? exp_closed : 4'hf;
    assign exp_installed = board_fitted;
endmodule

/* verif/drive_digital_input_conditioner_tb_top.sv */
// self-checking bench for the drive input conditioner
// assumes the design package, the design and the field contact model are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module drive_digital_input_conditioner_tb_top;
    localparam int unsigned QC = 20;
    localparam logic [7:0] A_NONE = 8'h40;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic base_closed = 1'b0;
    logic [3:0] exp_closed = 4'h0;
    logic board_fitted = 1'b1;
    logic exp_diag_fail = 1'b0;
    logic reverse_bridge_active = 1'b0;
    logic [15:0] analog_raw_first = 16'h0;
    logic [15:0] analog_raw_second = 16'h0;
    dio_pkg::cml_in_s cml_in = '0;
    logic [15:0] fire_cycles = 16'h0;
    logic base_discrete_input;
    logic exp_installed;
    logic pot_decrement;
    logic pot_increment;
    logic armature_permit;
    logic irq;
    logic [3:0] expansion_pins;
    logic [1:0] preset_sel;
    dio_pkg::base_fn_s base_fn;
    logic [31:0] rd;
    logic fn_bit;
    int n_mismatch = 0;
    int n_tests = 0;

    always #12.5 clk = ~clk;

    field_contacts i_field_contacts (.base_closed(base_closed), .exp_closed(exp_closed),
        .board_fitted(board_fitted), .base_discrete_input(base_discrete_input),
        .expansion_pins(expansion_pins), .exp_installed(exp_installed));

    dio_conditioner #(.QUAL_CYCLES(QC)) i_dio_conditioner (.clk(clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .base_discrete_input(base_discrete_input), .expansion_pins(expansion_pins),
        .exp_installed(exp_installed), .exp_diag_fail(exp_diag_fail),
        .reverse_bridge_active(reverse_bridge_active), .analog_raw_first(analog_raw_first),
        .analog_raw_second(analog_raw_second), .cml_in(cml_in), .fire_cycles(fire_cycles),
        .preset_sel(preset_sel), .pot_decrement(pot_decrement), .pot_increment(pot_increment),
        .armature_permit(armature_permit), .base_fn(base_fn), .irq(irq));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one single-word transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
        d = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0, rd);
        `CHK(rd & m, e)
    endtask

    task automatic test_done();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        n_mismatch++;
        test_done();
    end

    initial begin
        cyc(8);
        srst <= 1'b0;
        cyc(2);
        rchk(dio_pkg::A_CTRL, 32'h3, {30'h0, dio_pkg::CTRL_SEL_RST});
        `CHK(hresp, 1'b0)
        rchk(dio_pkg::A_STATUS, 32'h4000, 32'h4000);
        ahb(1'b1, A_NONE, 32'hffffffff, rd);
        rchk(A_NONE, 32'hffffffff, 32'h0);
        for (int s = 1; s <= 3; s++) begin
            for (int b = 0; b <= 1; b++) begin
                ahb(1'b1, dio_pkg::A_CTRL, 32'(s), rd);
                base_closed <= b[0];
                cyc(6);
                fn_bit = (s == 1) ? base_fn.brush_ok : (s == 2) ? base_fn.inch2 : base_fn.ocl_en;
                `CHK(fn_bit, b[0])
                rchk(dio_pkg::A_STATUS, 32'h1, 32'(b));
            end
        end
        // brushes worn event through the interrupt path
        ahb(1'b1, dio_pkg::A_IRQ_MASK, 32'h0, rd);
        ahb(1'b1, dio_pkg::A_CTRL, 32'h1, rd);
        cyc(6);
        ahb(1'b1, dio_pkg::A_IRQ_ST, 32'h1f, rd);
        base_closed <= 1'b0;
        cyc(6);
        rchk(dio_pkg::A_IRQ_ST, 32'h10, 32'h10);
        `CHK(irq, 1'b0)
        ahb(1'b1, dio_pkg::A_IRQ_MASK, 32'h10, rd);
        cyc(2);
        `CHK(irq, 1'b1)
        ahb(1'b1, dio_pkg::A_IRQ_ST, 32'h10, rd);
        cyc(2);
        `CHK(irq, 1'b0)
        // short assertion must not qualify
        exp_closed <= 4'hf;
        cyc(QC / 2);
        exp_closed <= 4'h0;
        cyc(QC);
        rchk(dio_pkg::A_STATUS, 32'h1e, 32'h0);
        for (int k = 0; k <= 3; k++) begin
            exp_closed <= {k[1], k[0], k[1], k[0]};
            cyc(QC / 2);
            `CHK(pot_decrement | pot_increment, 1'b0)
            cyc(QC + 6);
            `CHK(preset_sel == 2'h0, k == 0)
            `CHK(pot_decrement, k[0])
            `CHK(pot_increment, k[1])
            rchk(dio_pkg::A_STATUS, 32'h1e, {27'h0, k[1], k[0], k[1], k[0], 1'b0});
            exp_closed <= 4'h0;
            cyc(4);
            rchk(dio_pkg::A_STATUS, 32'h1e, 32'h0);
        end
        board_fitted <= 1'b0;
        exp_closed <= 4'hf;
        analog_raw_first <= 16'h0123;
        analog_raw_second <= 16'h0456;
        cyc(QC + 12);
        rchk(dio_pkg::A_STATUS, 32'h1e, 32'h0);
        rchk(dio_pkg::A_ANLG1, 32'hffff, 32'h0);
        board_fitted <= 1'b1;
        exp_closed <= 4'h0;
        cyc(QC + 12);
        rchk(dio_pkg::A_ANLG1, 32'hffff, 32'h0123);
        rchk(dio_pkg::A_ANLG2, 32'hffff, 32'h0456);
        // zero 0x10 and gain 2.0 on the first channel, zero 0x06 and gain 0.5 on the second
        ahb(1'b1, dio_pkg::A_ANLG_CAL, 32'h06100200, rd);
        ahb(1'b1, dio_pkg::A_GAIN2, 32'h00000080, rd);
        cyc(4);
        rchk(dio_pkg::A_ANLG_CAL, 32'hffffffff, 32'h06100200);
        rchk(dio_pkg::A_ANLG1, 32'hffff, 32'h0226);
        rchk(dio_pkg::A_ANLG2, 32'hffff, 32'h0228);
        reverse_bridge_active <= 1'b1;
        cyc(4);
        rchk(dio_pkg::A_STATUS, 32'h1000, 32'h1000);
        reverse_bridge_active <= 1'b0;
        cyc(4);
        rchk(dio_pkg::A_STATUS, 32'h1000, 32'h0);
        cml_in <= {16'h0064, 16'hffe2};
        cyc(20);
        rchk(dio_pkg::A_CML_REF, 32'hffff, 32'h0064);
        rchk(dio_pkg::A_CML_ERR, 32'hffff, 32'h0082);
        ahb(1'b1, dio_pkg::A_CML_LIM, 32'h00100020, rd);
        cyc(20);
        rchk(dio_pkg::A_CML_REF, 32'hffff, 32'h0020);
        rchk(dio_pkg::A_CML_ERR, 32'hffff, 32'h003e);
        fire_cycles <= 16'd4000;
        cyc(4);
        rchk(dio_pkg::A_FIRE_US, 32'hffff, 32'd100);
        exp_diag_fail <= 1'b1;
        cyc(4);
        `CHK(armature_permit, 1'b0)
        test_done();
    end
endmodule
